// File: nesr_pkg.sv
// constants, types and state codes of the erase and suspend sequencer
// Functional notes
// - opcode 20h plus 24-bit address erases the addressed 4 KB sector to ones
// - opcode 52h plus 24-bit address erases the addressed 32 KB block to ones
// - opcode D8h plus 24-bit address erases the addressed 64 KB block to ones
// - opcode C7h or 60h without address erases the whole array to ones
// - every erase needs the write enable latch set, else it is refused
// - sector and block erase need chip select rising right after bit 32
// - chip erase needs chip select rising right after the eighth opcode bit
// - a valid erase runs self-timed for the time of its erase size
// - busy is 1 during an erase, 0 after; status stays readable throughout
// - write enable latch clears when an erase completes
// - sector or block erase into a protected or locked region is refused
// - chip erase is refused if any region is protected or locked
// - suspend 75h accepted only with paused flag 0, busy 1, sector/block erase or program
// - suspend during chip erase is ignored and the chip erase continues
// - accepted suspend sets paused flag at once, busy drops within suspend latency
// - while erase is paused, status write and all erase opcodes are refused
// - while program is paused, status write and program opcodes are refused
// - resume 7Ah accepted only with paused flag 1 and busy 0
// - accepted resume clears paused flag at once, busy back within 200 ns
// - after power loss the paused flag is 0 and later resumes are ignored
package nesr_pkg;
    localparam logic [7:0] OP_SECTOR    = 8'h20;
    localparam logic [7:0] OP_BLK32     = 8'h52;
    localparam logic [7:0] OP_BLK64     = 8'hd8;
    localparam logic [7:0] OP_CHIP_A    = 8'hc7;
    localparam logic [7:0] OP_CHIP_B    = 8'h60;
    localparam logic [7:0] OP_REG_ERASE = 8'h44;
    localparam logic [7:0] OP_SUSPEND   = 8'h75;
    localparam logic [7:0] OP_RESUME    = 8'h7a;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_PROG      = 8'h02;
    localparam logic [7:0] OP_QPROG     = 8'h32;
    localparam logic [7:0] OP_REG_PROG  = 8'h42;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    // frame lengths in serial bits
    localparam logic [15:0] CMD_BITS      = 16'h0008;
    localparam logic [15:0] ADDR_CMD_BITS = 16'h0020;
    localparam logic [15:0] PROG_MIN_BITS = 16'h0028;
    localparam logic [15:0] BITS_MAX      = 16'hffff;
    // region sizes in bytes, array of 16 Mbit
    localparam logic [23:0] SECTOR_BYTES = 24'h001000;
    localparam logic [23:0] BLK32_BYTES  = 24'h008000;
    localparam logic [23:0] BLK64_BYTES  = 24'h010000;
    localparam logic [23:0] PAGE_BYTES   = 24'h000100;
    localparam logic [23:0] ARRAY_LAST   = 24'h1fffff;
    localparam int          BLOCK_SHIFT  = 16;
    localparam int          NUM_BLOCKS   = 32;
    // timing
    localparam int unsigned CLK_NS      = 10;
    localparam int unsigned SUSPEND_NS  = 20000;
    localparam int unsigned SUSPEND_CYC = SUSPEND_NS / CLK_NS;
    // reset values
    localparam logic [2:0] SYNC_RESET = 3'h7;
    typedef struct packed {
        logic       protect_complement;
        logic       protect_unit_small;
        logic       protect_from_bottom;
        logic [2:0] range; // protect_range_bits
    } nesr_prot_type;
    typedef struct packed {
        logic busy;
        logic write_enable_latch;
        logic paused_flag;
    } nesr_status_type;
    typedef struct packed {
        logic [23:0] base;
        logic [23:0] last;
        logic        is_prog;
    } nesr_job_type;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_RUN    = 4'b0010,
        ST_HALT   = 4'b0100,
        ST_PAUSED = 4'b1000
    } nesr_state_type;
endpackage

// File: nesr_top.sv
// serial nor erase, suspend and resume sequencer with its serial front end
`timescale 1ns/10ps
module nesr_top #(
    parameter int unsigned SECTOR_ERASE_US = 50,
    parameter int unsigned BLK32_ERASE_US  = 120,
    parameter int unsigned BLK64_ERASE_US  = 150,
    parameter int unsigned FULL_ERASE_MS   = 5000,
    parameter int unsigned PROG_US         = 400
) (
    // system clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst,
    // serial link
    input  wire logic                      i_sclk,
    input  wire logic                      i_cs_n,
    input  wire logic                      i_mosi,
    // protection settings and per 64 KB block locks
    input  wire nesr_pkg::nesr_prot_type   i_prot,
    input  wire logic [31:0]               i_block_lock,
    // status and operation reporting
    output nesr_pkg::nesr_status_type      o_status,
    output nesr_pkg::nesr_job_type         o_job,
    output logic                           o_job_start,
    output logic                           o_job_done,
    output logic                           o_refused
);
    // self-timed durations in cycles; one for each erase size, FULL_CYC for chip erase, and PROG_CYC
    localparam int unsigned SECTOR_CYC = SECTOR_ERASE_US * 1000 / nesr_pkg::CLK_NS;
    localparam int unsigned BLK32_CYC  = BLK32_ERASE_US * 1000 / nesr_pkg::CLK_NS;
    localparam int unsigned BLK64_CYC  = BLK64_ERASE_US * 1000 / nesr_pkg::CLK_NS;
    localparam int unsigned FULL_CYC   = FULL_ERASE_MS * (1000000 / nesr_pkg::CLK_NS);
    localparam int unsigned PROG_CYC   = PROG_US * 1000 / nesr_pkg::CLK_NS;

    // protection check of a region against the range bits and the locks
    function automatic logic region_blocked(input nesr_pkg::nesr_prot_type p, input logic [31:0] locks,
                                            input logic [23:0] lo, input logic [23:0] hi);
        logic [23:0] size;
        logic [23:0] plo;
        logic [23:0] phi;
        logic        none;
        logic        all;
        logic        hit;
        logic        lock_hit;
        size = '0;
        none = (p.range == 3'h0);
        all  = (p.range == 3'h7) || (!p.protect_unit_small && p.range >= 3'h6);
        // small units double from 4 KB and top out at 32 KB; large units double from 64 KB
        if (p.protect_unit_small) begin
            size = (p.range >= 3'h5) ? nesr_pkg::BLK32_BYTES : (nesr_pkg::SECTOR_BYTES << (p.range - 3'h1));
        end else begin
            size = nesr_pkg::BLK64_BYTES << (p.range - 3'h1);
        end
        // the protected span sits at the bottom or the top of the array
        plo = p.protect_from_bottom ? 24'h000000 : (nesr_pkg::ARRAY_LAST - size + 24'h000001);
        phi = p.protect_from_bottom ? (size - 24'h000001) : nesr_pkg::ARRAY_LAST;
        if (none || all) begin
            hit = all ^ p.protect_complement;
        end else if (p.protect_complement) begin
            hit = !(lo >= plo && hi <= phi); // complement: only the inside is writable
        end else begin
            hit = (lo <= phi) && (hi >= plo);
        end
        lock_hit = 1'b0;
        for (int b = 0; b < nesr_pkg::NUM_BLOCKS; b++) begin
            if (locks[b] && (lo >> nesr_pkg::BLOCK_SHIFT) <= 24'(b) && (hi >> nesr_pkg::BLOCK_SHIFT) >= 24'(b)) begin
                lock_hit = 1'b1;
            end
        end
        return hit || lock_hit;
    endfunction

    // ---------------- link domain, clocked by the serial clock ----------------
    logic        first_q;
    logic [31:0] shift_q;
    logic [15:0] bits_q;
    logic [7:0]  op_q;
    logic [23:0] addr_q;
    wire  [15:0] bits_next;
    wire  [31:0] shift_next;

    // the link clock stops outside frames, so a frame start is flagged by chip select itself
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    assign shift_next = {shift_q[30:0], i_mosi};                  // msb first
    assign bits_next  = first_q ? 16'h0001 :
                        (bits_q == nesr_pkg::BITS_MAX) ? bits_q : bits_q + 16'h0001;

    // bits sampled on the rising serial clock; opcode and address latched as they complete
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            shift_q <= '0;
            bits_q  <= '0;
            op_q    <= '0;
            addr_q  <= '0;
        end else begin
            shift_q <= shift_next;
            bits_q  <= bits_next;
            if (bits_next == nesr_pkg::CMD_BITS) begin
                op_q <= shift_next[7:0];
            end
            if (bits_next == nesr_pkg::ADDR_CMD_BITS) begin
                addr_q <= shift_next[23:0];
            end
        end
    end

    // ---------------- system domain ----------------
    logic [2:0] cs_sync_q;
    wire        frame_end;

    // chip select crosses through two flops; the third only serves the edge detector
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cs_sync_q <= nesr_pkg::SYNC_RESET;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], i_cs_n};
        end
    end

    // link registers are quiet once chip select is high, so they are read here unsynchronised
    assign frame_end = cs_sync_q[1] && !cs_sync_q[2];

    // frame decoding
    wire        is_8      = (bits_q == nesr_pkg::CMD_BITS);
    wire        is_32     = (bits_q == nesr_pkg::ADDR_CMD_BITS);
    wire        op_sector = (op_q == nesr_pkg::OP_SECTOR);
    wire        op_b32    = (op_q == nesr_pkg::OP_BLK32);
    wire        op_b64    = (op_q == nesr_pkg::OP_BLK64);
    wire        op_chip   = (op_q == nesr_pkg::OP_CHIP_A) || (op_q == nesr_pkg::OP_CHIP_B);
    wire        op_prog   = (op_q == nesr_pkg::OP_PROG) || (op_q == nesr_pkg::OP_QPROG);
    wire        op_any_er = op_sector || op_b32 || op_b64 || op_chip || (op_q == nesr_pkg::OP_REG_ERASE);
    wire        op_any_pg = op_prog || (op_q == nesr_pkg::OP_REG_PROG);
    wire        op_wsr    = (op_q == nesr_pkg::OP_WR_STATUS);
    wire        bits_ok   = bits_q >= nesr_pkg::PROG_MIN_BITS && bits_q[2:0] == 3'h0;
    wire        blk_cmd   = (op_sector || op_b32 || op_b64) && is_32;
    wire        chip_cmd  = op_chip && is_8;
    wire        prog_cmd  = op_prog && bits_ok;

    // region of the request
    wire [23:0] reg_size  = op_sector ? nesr_pkg::SECTOR_BYTES :
                            op_b32    ? nesr_pkg::BLK32_BYTES :
                            op_b64    ? nesr_pkg::BLK64_BYTES : nesr_pkg::PAGE_BYTES;
    wire [23:0] reg_lo    = op_chip ? 24'h000000 : (addr_q & ~(reg_size - 24'h000001));
    wire [23:0] reg_hi    = op_chip ? nesr_pkg::ARRAY_LAST : (reg_lo + reg_size - 24'h000001);
    wire        blocked   = region_blocked(i_prot, i_block_lock, reg_lo, reg_hi);
    wire [31:0] run_len   = op_sector ? SECTOR_CYC : op_b32 ? BLK32_CYC :
                            op_b64 ? BLK64_CYC : op_chip ? FULL_CYC : PROG_CYC;

    // state and status
    nesr_pkg::nesr_state_type state_q;
    nesr_pkg::nesr_state_type state_d;
    logic        wr_en_latch_q;
    logic        paused_q;
    logic        chip_job_q;
    logic [31:0] remain_q;
    logic [31:0] halt_q;

    // pause blocks: erase family in an erase pause, program family in a program pause
    wire pause_block = paused_q && (op_wsr || (o_job.is_prog ? op_any_pg : op_any_er));

    wire start_ok = frame_end && state_q == nesr_pkg::ST_IDLE && !paused_q && wr_en_latch_q
                    && (blk_cmd || chip_cmd || prog_cmd) && !blocked;
    wire susp_ok  = frame_end && is_8 && op_q == nesr_pkg::OP_SUSPEND && !paused_q
                    && state_q == nesr_pkg::ST_RUN && !chip_job_q;
    wire res_ok   = frame_end && is_8 && op_q == nesr_pkg::OP_RESUME && paused_q
                    && state_q == nesr_pkg::ST_PAUSED;
    wire we_set   = frame_end && is_8 && op_q == nesr_pkg::OP_WR_EN && !o_status.busy;
    wire we_clr   = frame_end && is_8 && op_q == nesr_pkg::OP_WR_DIS && !o_status.busy;
    // a suspend on the last running cycle wins: the job halts with one cycle left,
    // so completion, its pulse and the latch clear all wait for the resume
    wire run_end  = state_q == nesr_pkg::ST_RUN && remain_q == 32'h00000001 && !susp_ok;
    wire halt_end = state_q == nesr_pkg::ST_HALT && halt_q == 32'h00000001;
    wire refused  = frame_end && !start_ok && (pause_block || blk_cmd || chip_cmd || prog_cmd
                    || (is_8 && (op_q == nesr_pkg::OP_SUSPEND || op_q == nesr_pkg::OP_RESUME) && !susp_ok && !res_ok));

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            nesr_pkg::ST_IDLE: begin
                if (start_ok) begin
                    state_d = nesr_pkg::ST_RUN;
                end
            end
            nesr_pkg::ST_RUN: begin
                if (susp_ok) begin
                    state_d = nesr_pkg::ST_HALT;
                end else if (run_end) begin
                    state_d = nesr_pkg::ST_IDLE;
                end
            end
            nesr_pkg::ST_HALT: begin
                if (halt_end) begin
                    state_d = nesr_pkg::ST_PAUSED;                // busy falls within the latency
                end
            end
            nesr_pkg::ST_PAUSED: begin
                if (res_ok) begin
                    state_d = nesr_pkg::ST_RUN;                   // busy back next cycle
                end
            end
            default: begin
                state_d = nesr_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer registers; reset models power loss, which also drops any pause
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q    <= nesr_pkg::ST_IDLE;
            paused_q   <= 1'b0;
            chip_job_q <= 1'b0;
            remain_q   <= '0;
            halt_q     <= '0;
        end else begin
            state_q <= state_d;
            if (susp_ok) begin
                paused_q <= 1'b1;
            end else if (res_ok) begin
                paused_q <= 1'b0;
            end
            if (start_ok) begin
                chip_job_q <= chip_cmd;
                remain_q   <= run_len;
            end else if (state_q == nesr_pkg::ST_RUN && !susp_ok) begin
                remain_q <= remain_q - 32'h00000001;               // remaining time held while paused
            end
            if (susp_ok) begin
                halt_q <= nesr_pkg::SUSPEND_CYC;
            end else if (state_q == nesr_pkg::ST_HALT) begin
                halt_q <= halt_q - 32'h00000001;
            end
        end
    end

    // write enable latch: completion clears it and wins over a set
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_en_latch_q <= 1'b0;
        end else if (run_end || we_clr) begin
            wr_en_latch_q <= 1'b0;
        end else if (we_set) begin
            wr_en_latch_q <= 1'b1;
        end
    end

    // job report to the array: the region to set to all ones, or the page to program
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_job       <= '0;
            o_job_start <= 1'b0;
            o_job_done  <= 1'b0;
            o_refused   <= 1'b0;
        end else begin
            o_job_start <= start_ok;
            o_job_done  <= run_end;
            o_refused   <= refused;
            if (start_ok) begin
                o_job.base    <= reg_lo;
                o_job.last    <= reg_hi;
                o_job.is_prog <= prog_cmd;
            end
        end
    end

    // status is live in every state, including during a running erase
    assign o_status.busy               = (state_q == nesr_pkg::ST_RUN) || (state_q == nesr_pkg::ST_HALT);
    assign o_status.write_enable_latch = wr_en_latch_q;
    assign o_status.paused_flag        = paused_q;
endmodule

// File: nesr_properties.sv
// concurrent checks on the ports of the erase and suspend sequencer
`timescale 1ns/10ps
module nesr_properties (
    // clock and reset
    input wire logic                      i_clock,
    input wire logic                      i_rst,
    // observed outputs
    input wire nesr_pkg::nesr_status_type o_status,
    input wire nesr_pkg::nesr_job_type    o_job,
    input wire logic                      o_job_start,
    input wire logic                      o_job_done,
    input wire logic                      o_refused
);
    localparam int SUSP_MAX = 2000;
    logic [11:0] held_q;
    logic [23:0] span;
    assign span = o_job.last - o_job.base;
    // cycles spent paused but still busy; too long a count means the suspend never lands
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            held_q <= 12'h000;
        end else begin
            held_q <= (o_status.paused_flag && o_status.busy) ? held_q + 12'h001 : 12'h000;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_start_needs_latch: assert property (o_job_start |-> o_status.write_enable_latch && o_status.busy)
        else $error("job started without write enable or busy");
    chk_refuse_no_start: assert property (o_refused |-> !o_job_start)
        else $error("refusal and start in one cycle");
    chk_region_shape: assert property (o_job_start && !o_job.is_prog |->
        ((span & o_job.base) == 24'h0) && (((span + 24'h1) & span) == 24'h0) && o_job.last <= nesr_pkg::ARRAY_LAST)
        else $error("erase region not an aligned power of two");
    chk_done_clears: assert property (o_job_done |-> ##[0:2] (!o_status.busy && !o_status.write_enable_latch))
        else $error("busy or write enable left set after completion");
    chk_suspend_bound: assert property (held_q <= SUSP_MAX)
        else $error("busy held too long after suspend");
    chk_pause_busy: assert property ($rose(o_status.paused_flag) |-> o_status.busy)
        else $error("suspend taken while not busy");
    chk_resume_busy: assert property ($fell(o_status.paused_flag) |-> ##[0:20] o_status.busy)
        else $error("busy not back within 200 ns of resume");
    chk_no_start_paused: assert property (o_status.paused_flag |-> !o_job_start)
        else $error("job started while paused");
    chk_job_held: assert property (!o_job_start |-> $stable(o_job))
        else $error("job region changed without a start");
    chk_busy_cause: assert property ($rose(o_status.busy) |->
        o_job_start || $past(o_status.paused_flag) || $past(o_status.paused_flag, 2))
        else $error("busy rose without start or resume");
endmodule
bind nesr_top nesr_properties chk_inst (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .o_status    (o_status),
    .o_job       (o_job),
    .o_job_start (o_job_start),
    .o_job_done  (o_job_done),
    .o_refused   (o_refused)
);

// File: nesr_host_model.sv
// host side serial controller model: frames opcode, address and data bits
`timescale 1ns/10ps
module nesr_host_model (
    // serial link toward the device
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b1;
    end
    // clock runs only inside frames and in tick; data is inverted after a frame so a stale bit never looks valid
    task automatic frame(input logic [39:0] bits, input int n);
        int k;
        o_cs_n = 1'b0;
        for (k = 39; k > 39 - n; k--) begin
            o_mosi = bits[k]; // msb first
            #6 o_sclk = 1'b1; // sampled on the rising edge
            #6 o_sclk = 1'b0;
        end
        #6 o_cs_n = 1'b1; // rises right after the last bit
        o_mosi = ~o_mosi;
        #80;
    endtask
    // one serial edge with select high, used only while the device is held in reset
    task automatic tick();
        #6 o_sclk = 1'b1;
        #6 o_sclk = 1'b0;
    endtask
endmodule

// File: tb_nor_erase_suspend_resume.sv
// self-checking bench for the erase, suspend and resume sequencer
`timescale 1ns/10ps
module tb_nor_erase_suspend_resume;
    logic                      i_clock;
    logic                      i_rst;
    logic                      sclk, cs_n, mosi;
    nesr_pkg::nesr_prot_type   i_prot;
    logic [31:0]               i_block_lock;
    nesr_pkg::nesr_status_type o_status;
    nesr_pkg::nesr_job_type    o_job;
    logic                      o_job_start, o_job_done, o_refused;
    int                        fails, tests_run, n_start, n_ref, n_done, k;
    logic [7:0]                eops [3] = '{8'h20, 8'h52, 8'hd8};
    logic [47:0]               ereg [3] = '{48'h01a00001afff, 48'h01800001ffff, 48'h01000001ffff};
    logic [7:0]                bad  [7] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h44, 8'h01};
    int                        blen [7] = '{32, 32, 32, 8, 8, 32, 16};
    logic [7:0]                pbad [3] = '{8'h32, 8'h42, 8'h01};
    int                        plen [3] = '{40, 40, 16};

    initial i_clock = 1'b0;
    always #5 i_clock = ~i_clock;
    // pulse tallies, so each command can be judged by what it produced
    always @(posedge i_clock) begin
        n_start += int'(o_job_start);
        n_ref += int'(o_refused);
        n_done += int'(o_job_done);
    end

    nesr_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
    // the longer sector erase time keeps the job alive across the suspend latency
    nesr_top #(.SECTOR_ERASE_US(30), .BLK32_ERASE_US(1), .BLK64_ERASE_US(1), .FULL_ERASE_MS(1), .PROG_US(5)) DUT (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_sclk       (sclk),
        .i_cs_n       (cs_n),
        .i_mosi       (mosi),
        .i_prot       (i_prot),
        .i_block_lock (i_block_lock),
        .o_status     (o_status),
        .o_job        (o_job),
        .o_job_start  (o_job_start),
        .o_job_done   (o_job_done),
        .o_refused    (o_refused)
    );

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one frame, then count the starts and refusals it caused
    task automatic cmd(input logic [7:0] op, input logic [23:0] addr, input int n, input int st, input int rf);
        int s0;
        int r0;
        s0 = n_start;
        r0 = n_ref;
        host.frame({op, addr, 8'h5a}, n);
        repeat (4) @(posedge i_clock);
        #1;
        check(64'(n_start - s0), 64'(st));
        check(64'(n_ref - r0), 64'(rf));
    endtask
    task automatic wait_idle();
        int w;
        for (w = 0; w < 4000 && o_status.busy !== 1'b0; w++)
            @(posedge i_clock);
        #1;
        if (w == 4000) begin
            fails++;
            results();
        end
    endtask
    // reset doubles as a power loss; a serial edge lands while it is held
    task automatic power_cycle();
        @(posedge i_clock);
        #1 i_rst = 1'b1;
        host.tick();
        @(posedge i_clock);
        #1 i_rst = 1'b0;
    endtask

    initial begin
        i_rst = 1'b1;
        i_prot = '0;
        i_block_lock = 32'h0;
        fails = 0;
        tests_run = 0;
        n_start = 0;
        n_ref = 0;
        n_done = 0;
        host.tick();
        repeat (10) @(posedge i_clock);
        #1 i_rst = 1'b0;
        check(64'(o_status), 64'h0);
        cmd(8'h06, 24'h0, 8, 0, 0);
        check(64'(o_status), 64'h2);
        cmd(8'h04, 24'h0, 8, 0, 0);
        cmd(8'h20, 24'h012345, 32, 0, 1);
        // each erase size: region, busy while running, latch cleared after
        for (k = 0; k < 3; k++) begin
            cmd(8'h06, 24'h0, 8, 0, 0);
            cmd(eops[k], 24'h01abcd, 32, 1, 0);
            check(64'({o_job.base, o_job.last}), 64'(ereg[k]));
            check(64'(o_status), 64'h6);
            wait_idle();
            check(64'(o_status), 64'h0);
        end
        cmd(8'h06, 24'h0, 8, 0, 0);
        check(64'(n_done), 64'h3);
        // a frame of the wrong length is dropped without a refusal pulse
        cmd(8'h20, 24'h0, 31, 0, 0);
        cmd(8'hd8, 24'h0, 40, 0, 0);
        cmd(8'h60, 24'h0, 16, 0, 0);
        check(64'(o_status), 64'h2);
        i_block_lock = 32'h0000_0002;
        cmd(8'hd8, 24'h010000, 32, 0, 1);
        cmd(8'hc7, 24'h0, 8, 0, 1);
        i_block_lock = 32'h0;
        i_prot.range = 3'h7;
        cmd(8'h20, 24'h1ff000, 32, 0, 1);
        // bottom 4 KB protected, then only that 4 KB left writable
        i_prot = '{1'b0, 1'b1, 1'b1, 3'h1};
        cmd(8'h20, 24'h000800, 32, 0, 1);
        i_prot.protect_complement = 1'b1;
        cmd(8'h52, 24'h000000, 32, 0, 1);
        i_prot = '0;
        cmd(8'h75, 24'h0, 8, 0, 1);
        cmd(8'h7a, 24'h0, 8, 0, 1);
        cmd(8'h20, 24'h0, 32, 1, 0);
        cmd(8'h75, 24'h0, 8, 0, 0);
        check(64'(o_status), 64'h7);
        wait_idle();
        check(64'(o_status), 64'h3);
        for (k = 0; k < 7; k++)
            cmd(bad[k], 24'h020000, blen[k], 0, 1);
        cmd(8'h7a, 24'h0, 8, 0, 0);
        check(64'(o_status), 64'h6);
        wait_idle();
        check(64'(o_status), 64'h0);
        repeat (2000) @(posedge i_clock); // host keeps the suspend latency after a resume
        #1;
        check(64'(n_done), 64'h4);
        cmd(8'h06, 24'h0, 8, 0, 0);
        cmd(8'h02, 24'h000100, 40, 1, 0);
        check(64'(o_job.is_prog), 64'h1);
        cmd(8'h75, 24'h0, 8, 0, 0);
        wait_idle();
        for (k = 0; k < 3; k++)
            cmd(pbad[k], 24'h000100, plen[k], 0, 1);
        power_cycle();
        check(64'(o_status), 64'h0);
        cmd(8'h7a, 24'h0, 8, 0, 1);
        check(64'(o_status), 64'h0);
        // both chip erase codes; suspend is ignored, then power loss cuts the long erase
        for (k = 0; k < 2; k++) begin
            cmd(8'h06, 24'h0, 8, 0, 0);
            cmd(k ? 8'h60 : 8'hc7, 24'h0, 8, 1, 0);
            check(64'({o_job.base, o_job.last}), 64'({24'h0, nesr_pkg::ARRAY_LAST}));
            cmd(8'h75, 24'h0, 8, 0, 1);
            check(64'(o_status), 64'h6);
            power_cycle();
        end
        results();
    end
endmodule
